/* rtl/mem_ctl_pkg.sv */
package mem_ctl_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_SDRAM_CFG = 8'h08;
   localparam logic [7:0] OFS_SDRAM_TIMING = 8'h20;
   localparam logic [7:0] OFS_SR_EXIT_TIMING = 8'h3C;
   localparam logic [7:0] OFS_PAGE_MODE = 8'h68;
   localparam logic [7:0] OFS_STATUS = 8'h74;

   // Reset values
   localparam logic [31:0] RST_PAGE_MODE = 32'hFCFC_FCFC;
   localparam logic [31:0] RST_SDRAM_TIMING = 32'hFF77_F770;
   localparam logic [31:0] RST_SR_EXIT_TIMING = 32'h0000_001F;
   localparam logic [31:0] RST_SDRAM_CFG = 32'h0000_0000;

   // Writable bits; all others read as zero
   localparam logic [31:0] MSK_PAGE_MODE = 32'hFFFF_FFFF;
   localparam logic [31:0] MSK_SDRAM_TIMING = 32'hFF77_F770;
   localparam logic [31:0] MSK_SR_EXIT_TIMING = 32'h0000_001F;
   localparam logic [31:0] MSK_SDRAM_CFG = 32'h8000_FFFF;

   // Page-mode byte layout: one byte per chip select
   localparam int PG_BYTE_W = 8;
   localparam int PG_EN_BIT = 0;
   localparam int PG_LEN_BIT = 1;
   localparam int PG_DEL_LSB = 2;
   localparam int PG_DEL_W = 6;
   localparam int PG_CS_COUNT = 3;

   // Self-refresh request bit in the configuration register
   localparam int SR_REQ_BIT = 31;
   localparam int CFG_UPPER_LANE = 3;

   // Timing field positions (lsb) and widths
   localparam int TF_RFC_LSB = 27;
   localparam int TF_RP_LSB = 24;
   localparam int TF_RCD_LSB = 20;
   localparam int TF_WR_LSB = 16;
   localparam int TF_RAS_LSB = 12;
   localparam int TF_RC_LSB = 8;
   localparam int TF_RRD_LSB = 4;
   localparam int TF_XS_LSB = 0;
   localparam int GAP_W = 5;

   // Page sizes in words, as address bits
   localparam int PAGE4_BITS = 2;
   localparam int PAGE8_BITS = 3;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // SDRAM command codes
   typedef enum logic [2:0] {
      SD_ACTIVATE = 3'h0,
      SD_READ = 3'h1,
      SD_WRITE = 3'h2,
      SD_PRECHARGE = 3'h3,
      SD_REFRESH = 3'h4,
      SD_SELF_REFRESH = 3'h5
   } sd_cmd_t;

   // Self-refresh states, Gray along run-enter-held-exit
   typedef enum logic [1:0] {
      SR_RUN = 2'h0,
      SR_ENTER = 2'h1,
      SR_HELD = 2'h3,
      SR_EXIT = 2'h2
   } sr_state_t;

   // Page read engine states
   typedef enum logic {
      NOR_IDLE = 1'h0,
      NOR_WAIT = 1'h1
   } nor_state_t;

endpackage : mem_ctl_pkg

/* rtl/mem_ctl_timing.sv */
// Function
// - Per-select page enable bit, resets off
// - Page length bit: 0 four, 1 eight words
// - Six-bit page delay is cycles minus one
// - Absent select's page fields affect nothing
// - One field byte per select, fixed bits
// - Upper-byte write sets self-refresh, no init
// - Timing fields give minimum spacing minus one
// - Wait exit field plus one after self-refresh
// - Timing field bit positions, low nibble reserved
// - Request bit one enters, zero leaves self-refresh
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps

module mem_ctl_timing #(
   parameter int ADDR_W = 22,
   parameter int FULL_READ_CYCLES = 12
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // NOR read requests
   input wire logic nor_rd_valid,
   input wire logic [1:0] nor_rd_cs,
   input wire logic [ADDR_W-1:0] nor_rd_addr,
   output logic nor_rd_ready,
   output logic nor_rd_done,
   output logic nor_rd_page_hit,
   // SDRAM command requests
   input wire logic sd_cmd_valid,
   input wire logic [2:0] sd_cmd_kind,
   input wire logic [1:0] sd_cmd_bank,
   output logic sd_cmd_ready,
   output logic sd_cmd_issue,
   output logic [2:0] sd_issue_kind,
   output logic sd_cke,
   output logic sd_init_start
);

   // Local copies of package widths; the state struct below needs them
   localparam int PG_DEL_W_L = mem_ctl_pkg::PG_BYTE_W;
   localparam int PG_CS_COUNT_L = mem_ctl_pkg::PG_CS_COUNT;
   localparam int GAP_W_L = mem_ctl_pkg::GAP_W;

   // Complete state of the block
   typedef struct packed {
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] page_mode;
      logic [31:0] sd_timing;
      logic [31:0] sr_exit;
      logic [31:0] sd_cfg;
      logic init_start;
      mem_ctl_pkg::nor_state_t nor_st;
      logic [PG_DEL_W_L:0] nor_cnt;
      logic [PG_CS_COUNT_L*ADDR_W-1:0] last_page;
      logic [PG_CS_COUNT_L-1:0] last_ok;
      logic nor_ready;
      logic nor_done;
      logic nor_hit;
      mem_ctl_pkg::sr_state_t sr_st;
      logic [GAP_W_L-1:0] gap;
      logic [GAP_W_L-1:0] act_gap;
      logic [GAP_W_L-1:0] ras_gap;
      logic [1:0] last_bank;
      logic cmd_ready;
      logic cmd_issue;
      logic [2:0] issue_kind;
      logic cke;
   } state_t;

   state_t st_r; // Registered state
   state_t st_nxt; // Next state

   // Merge write data into a register under byte strobes and a mask
   function automatic logic [31:0] wmerge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb,
      input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            res[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      return res & mask;
   endfunction : wmerge

   // Extract a timing field, zero-extended to the gap width
   function automatic logic [GAP_W_L-1:0] tfield(input logic [31:0] r,
      input int lsb, input int w);
      logic [GAP_W_L-1:0] v;
      v = '0;
      for (int i = 0; i < GAP_W_L; i++)
      begin
         if (i < w)
         begin
            v[i] = r[lsb + i];
         end
      end
      return v;
   endfunction : tfield

   // Page number of an address for the given page length bit
   function automatic logic [ADDR_W-1:0] page_of(
      input logic [ADDR_W-1:0] a, input logic len8);
      logic [ADDR_W-1:0] p;
      p = len8 ? (a >> mem_ctl_pkg::PAGE8_BITS)
               : (a >> mem_ctl_pkg::PAGE4_BITS);
      return p;
   endfunction : page_of

   // Next-state logic: bus slave, page engine, command spacing
   always_comb
   begin
      logic [7:0] pg_byte;
      logic [PG_DEL_W_L:0] del;
      logic [ADDR_W-1:0] pg;
      logic hit;
      logic issue;
      logic sr_req;
      int cs;
      pg_byte = '0;
      del = '0;
      pg = '0;
      hit = 1'b0;
      issue = 1'b0;
      sr_req = 1'b0;
      cs = 0;
      st_nxt = st_r;
      st_nxt.init_start = 1'b0;
      st_nxt.nor_done = 1'b0;
      st_nxt.cmd_issue = 1'b0;

      // Capture write address and data in either order
      if (s_axi_awvalid && st_r.awready)
      begin
         st_nxt.aw_have = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.wready)
      begin
         st_nxt.w_have = 1'b1;
         st_nxt.w_data = s_axi_wdata;
         st_nxt.w_strb = s_axi_wstrb;
      end

      // Perform the write once both halves are held
      if (st_r.aw_have && st_r.w_have && !st_r.bvalid)
      begin
         st_nxt.aw_have = 1'b0;
         st_nxt.w_have = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = mem_ctl_pkg::RESP_OKAY;
         unique case (st_r.aw_addr)
            mem_ctl_pkg::OFS_PAGE_MODE:
               st_nxt.page_mode = wmerge(st_r.page_mode, st_r.w_data,
                  st_r.w_strb, mem_ctl_pkg::MSK_PAGE_MODE);
            mem_ctl_pkg::OFS_SDRAM_TIMING:
               st_nxt.sd_timing = wmerge(st_r.sd_timing, st_r.w_data,
                  st_r.w_strb, mem_ctl_pkg::MSK_SDRAM_TIMING);
            mem_ctl_pkg::OFS_SR_EXIT_TIMING:
               st_nxt.sr_exit = wmerge(st_r.sr_exit, st_r.w_data,
                  st_r.w_strb, mem_ctl_pkg::MSK_SR_EXIT_TIMING);
            mem_ctl_pkg::OFS_SDRAM_CFG:
            begin
               st_nxt.sd_cfg = wmerge(st_r.sd_cfg, st_r.w_data,
                  st_r.w_strb, mem_ctl_pkg::MSK_SDRAM_CFG);
               // Only a write reaching the lower lanes starts init
               st_nxt.init_start =
                  |st_r.w_strb[mem_ctl_pkg::CFG_UPPER_LANE-1:0];
            end
            mem_ctl_pkg::OFS_STATUS:
               st_nxt.bresp = mem_ctl_pkg::RESP_OKAY;
            default:
               st_nxt.bresp = mem_ctl_pkg::RESP_SLVERR;
         endcase
      end
      else if (st_r.bvalid && s_axi_bready)
      begin
         st_nxt.bvalid = 1'b0;
      end
      st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
      st_nxt.wready = !st_nxt.w_have && !st_nxt.bvalid;

      // Read channel: answer one cycle after the address is taken
      if (s_axi_arvalid && st_r.arready)
      begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = mem_ctl_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            mem_ctl_pkg::OFS_PAGE_MODE: st_nxt.rdata = st_r.page_mode;
            mem_ctl_pkg::OFS_SDRAM_TIMING: st_nxt.rdata = st_r.sd_timing;
            mem_ctl_pkg::OFS_SR_EXIT_TIMING: st_nxt.rdata = st_r.sr_exit;
            mem_ctl_pkg::OFS_SDRAM_CFG: st_nxt.rdata = st_r.sd_cfg;
            mem_ctl_pkg::OFS_STATUS:
               st_nxt.rdata = {27'h0, !st_r.nor_ready, st_r.cke,
                  st_r.cmd_ready, st_r.sr_st};
            default:
            begin
               st_nxt.rdata = '0;
               st_nxt.rresp = mem_ctl_pkg::RESP_SLVERR;
            end
         endcase
      end
      else if (st_r.rvalid && s_axi_rready)
      begin
         st_nxt.rvalid = 1'b0;
      end
      st_nxt.arready = !st_nxt.rvalid;

      // Page read engine; the absent fourth byte is never indexed
      unique case (st_r.nor_st)
         mem_ctl_pkg::NOR_IDLE:
            if (nor_rd_valid && st_r.nor_ready &&
                nor_rd_cs < 2'(PG_CS_COUNT_L))
            begin
               cs = int'(nor_rd_cs);
               pg_byte = st_r.page_mode[cs*mem_ctl_pkg::PG_BYTE_W +: 8];
               pg = page_of(nor_rd_addr,
                  pg_byte[mem_ctl_pkg::PG_LEN_BIT]);
               del = {3'h0, pg_byte[7:mem_ctl_pkg::PG_DEL_LSB]};
               hit = pg_byte[mem_ctl_pkg::PG_EN_BIT] && st_r.last_ok[cs]
                  && st_r.last_page[cs*ADDR_W +: ADDR_W] == pg;
               // Hit waits delay+1, miss pays the whole access
               st_nxt.nor_cnt = hit ? del
                  : (PG_DEL_W_L+1)'(FULL_READ_CYCLES - 1);
               st_nxt.nor_hit = hit;
               st_nxt.last_page[cs*ADDR_W +: ADDR_W] = pg;
               st_nxt.last_ok[cs] = pg_byte[mem_ctl_pkg::PG_EN_BIT];
               st_nxt.nor_st = mem_ctl_pkg::NOR_WAIT;
               st_nxt.nor_ready = 1'b0;
            end
         mem_ctl_pkg::NOR_WAIT:
            if (st_r.nor_cnt == '0)
            begin
               st_nxt.nor_done = 1'b1;
               st_nxt.nor_ready = 1'b1;
               st_nxt.nor_st = mem_ctl_pkg::NOR_IDLE;
            end
            else
            begin
               st_nxt.nor_cnt = st_r.nor_cnt - 1'b1;
            end
      endcase
      // Ready follows the engine state, so it comes up after reset
      st_nxt.nor_ready = st_nxt.nor_st == mem_ctl_pkg::NOR_IDLE;

      // Spacing counters run down toward zero
      if (st_r.gap != '0) st_nxt.gap = st_r.gap - 1'b1;
      if (st_r.act_gap != '0) st_nxt.act_gap = st_r.act_gap - 1'b1;
      if (st_r.ras_gap != '0) st_nxt.ras_gap = st_r.ras_gap - 1'b1;

      // Command issue: a spacing counter loaded with a field delays
      // the next command by field+1 cycles
      sr_req = st_r.sd_cfg[mem_ctl_pkg::SR_REQ_BIT];
      issue = sd_cmd_valid && st_r.cmd_ready;
      if (issue)
      begin
         st_nxt.cmd_issue = 1'b1;
         st_nxt.issue_kind = sd_cmd_kind;
         unique case (sd_cmd_kind)
            mem_ctl_pkg::SD_ACTIVATE:
            begin
               st_nxt.gap = tfield(st_r.sd_timing,
                  mem_ctl_pkg::TF_RCD_LSB, 3);
               st_nxt.ras_gap = tfield(st_r.sd_timing,
                  mem_ctl_pkg::TF_RAS_LSB, 4);
               st_nxt.act_gap = (sd_cmd_bank == st_r.last_bank)
                  ? tfield(st_r.sd_timing, mem_ctl_pkg::TF_RC_LSB, 4)
                  : tfield(st_r.sd_timing, mem_ctl_pkg::TF_RRD_LSB, 3);
               st_nxt.last_bank = sd_cmd_bank;
            end
            mem_ctl_pkg::SD_WRITE:
               st_nxt.gap = tfield(st_r.sd_timing,
                  mem_ctl_pkg::TF_WR_LSB, 3);
            mem_ctl_pkg::SD_PRECHARGE:
               st_nxt.gap = tfield(st_r.sd_timing,
                  mem_ctl_pkg::TF_RP_LSB, 3);
            mem_ctl_pkg::SD_REFRESH:
               st_nxt.gap = tfield(st_r.sd_timing,
                  mem_ctl_pkg::TF_RFC_LSB, 5);
            default:
               st_nxt.gap = '0;
         endcase
      end

      // Self-refresh sequencing
      unique case (st_r.sr_st)
         mem_ctl_pkg::SR_RUN:
            if (sr_req && !issue)
            begin
               st_nxt.sr_st = mem_ctl_pkg::SR_ENTER;
            end
         mem_ctl_pkg::SR_ENTER:
            if (st_r.gap == '0 && st_r.act_gap == '0 &&
                st_r.ras_gap == '0)
            begin
               st_nxt.cmd_issue = 1'b1;
               st_nxt.issue_kind = mem_ctl_pkg::SD_SELF_REFRESH;
               st_nxt.cke = 1'b0;
               st_nxt.sr_st = mem_ctl_pkg::SR_HELD;
            end
         mem_ctl_pkg::SR_HELD:
            if (!sr_req)
            begin
               st_nxt.cke = 1'b1;
               st_nxt.gap = tfield(st_r.sr_exit,
                  mem_ctl_pkg::TF_XS_LSB, 5);
               st_nxt.sr_st = mem_ctl_pkg::SR_EXIT;
            end
         mem_ctl_pkg::SR_EXIT:
            if (st_r.gap == '0)
            begin
               st_nxt.sr_st = mem_ctl_pkg::SR_RUN;
            end
      endcase

      // Ready only in run with every spacing elapsed
      st_nxt.cmd_ready = st_nxt.sr_st == mem_ctl_pkg::SR_RUN && !sr_req
         && st_nxt.gap == '0 && st_nxt.act_gap == '0
         && st_nxt.ras_gap == '0;
   end

   // State register with synchronous reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r <= '0;
         st_r.page_mode <= mem_ctl_pkg::RST_PAGE_MODE;
         st_r.sd_timing <= mem_ctl_pkg::RST_SDRAM_TIMING;
         st_r.sr_exit <= mem_ctl_pkg::RST_SR_EXIT_TIMING;
         st_r.sd_cfg <= mem_ctl_pkg::RST_SDRAM_CFG;
         st_r.nor_st <= mem_ctl_pkg::NOR_IDLE;
         st_r.sr_st <= mem_ctl_pkg::SR_RUN;
         st_r.issue_kind <= mem_ctl_pkg::SD_ACTIVATE;
         st_r.bresp <= mem_ctl_pkg::RESP_OKAY;
         st_r.rresp <= mem_ctl_pkg::RESP_OKAY;
         st_r.cke <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign s_axi_awready = st_r.awready;
   assign s_axi_wready = st_r.wready;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = st_r.arready;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign nor_rd_ready = st_r.nor_ready;
   assign nor_rd_done = st_r.nor_done;
   assign nor_rd_page_hit = st_r.nor_hit;
   assign sd_cmd_ready = st_r.cmd_ready;
   assign sd_cmd_issue = st_r.cmd_issue;
   assign sd_issue_kind = st_r.issue_kind;
   assign sd_cke = st_r.cke;
   assign sd_init_start = st_r.init_start;

endmodule : mem_ctl_timing

/* tb/mem_ctl_monitor.sv */
`timescale 1ns/1ps
module mem_ctl_checker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register write bus
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   // NOR page engine
   input wire logic nor_rd_valid,
   input wire logic [1:0] nor_rd_cs,
   input wire logic nor_rd_ready,
   input wire logic nor_rd_done,
   // SDRAM command path
   input wire logic sd_cmd_valid,
   input wire logic [2:0] sd_cmd_kind,
   input wire logic sd_cmd_ready,
   input wire logic sd_cmd_issue,
   input wire logic [2:0] sd_issue_kind,
   input wire logic sd_cke,
   input wire logic sd_init_start
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Both write halves taken at one edge
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // Configuration write touching only the upper lane
   sequence cfg_hi;
      wr_take ##0 (s_axi_awaddr == mem_ctl_pkg::OFS_SDRAM_CFG
         && s_axi_wstrb == 4'h8);
   endsequence
   // Configuration write touching the lowest lane
   sequence cfg_lo;
      wr_take ##0 (s_axi_awaddr == mem_ctl_pkg::OFS_SDRAM_CFG
         && s_axi_wstrb[0]);
   endsequence
   // Page read taken on a present select
   sequence nor_take;
      nor_rd_valid && nor_rd_ready && nor_rd_cs != 2'h3;
   endsequence
   // SDRAM command taken
   sequence sd_take;
      sd_cmd_valid && sd_cmd_ready;
   endsequence
   AST_WR_RESP: assert property (wr_take |-> ##2 s_axi_bvalid)
      else $error("write response late");
   AST_CFG_NOINIT: assert property (cfg_hi |-> ##1 !sd_init_start [*4])
      else $error("init on upper lane write");
   AST_CFG_INIT: assert property (cfg_lo |-> ##[1:4] sd_init_start)
      else $error("init missing");
   AST_NOR_BUSY: assert property (nor_take |=> !nor_rd_ready)
      else $error("page engine not busy");
   AST_NOR_DONE: assert property (nor_take |-> ##[2:66] nor_rd_done)
      else $error("page read never done");
   AST_NOR_ABSENT: assert property ((nor_rd_valid && nor_rd_ready
      && nor_rd_cs == 2'h3) |=> nor_rd_ready && !nor_rd_done)
      else $error("absent select acted");
   AST_SD_ISSUE: assert property (sd_take |=> sd_cmd_issue)
      else $error("taken command not issued");
   AST_SD_KIND: assert property (sd_take |=>
      sd_issue_kind == $past(sd_cmd_kind))
      else $error("issued kind wrong");
   AST_SR_HOLD: assert property (!sd_cke |-> !sd_cmd_ready)
      else $error("command ready in self-refresh");
   AST_SR_ENTER: assert property ($fell(sd_cke) |->
      sd_issue_kind == mem_ctl_pkg::SD_SELF_REFRESH)
      else $error("entry without self-refresh command");
   AST_SR_QUIET: assert property ((sd_cmd_issue && !sd_cke) |->
      sd_issue_kind == mem_ctl_pkg::SD_SELF_REFRESH)
      else $error("command issued in self-refresh");
   AST_SR_EXIT: assert property ($rose(sd_cke) |-> !sd_cmd_ready)
      else $error("no exit wait");
endmodule : mem_ctl_checker

bind mem_ctl_timing mem_ctl_checker chk_i (.*);

/* tb/sdram_model.sv */
`timescale 1ns/1ps
module sdram_model (
   // Clock
   input wire logic aclk,
   // Controller pins seen by the memory
   input wire logic sd_cmd_issue,
   input wire logic [2:0] sd_issue_kind,
   input wire logic sd_cke,
   // Measured spacing and fault flag
   output int gap,
   output int xs_gap,
   output logic bad = 1'b0
);
   int since_cmd = 0; // Edges since last command
   int since_cke = 0; // Edges since clock enable high
   // Track command spacing and commands in self-refresh
   always @(posedge aclk)
   begin
      since_cmd <= sd_cmd_issue ? 1 : since_cmd + 1;
      since_cke <= sd_cke ? since_cke + 1 : 0;
      if (sd_cmd_issue)
      begin
         gap <= since_cmd;
         xs_gap <= since_cke;
         if (!sd_cke && sd_issue_kind != 3'h5) bad <= 1'b1;
      end
   end
endmodule : sdram_model

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   integer seed = 84;
   int errors = 0;
   int total_checks = 0;
   int init_seen = 0;
   // Register bus, responses always accepted
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   // Page engine and SDRAM command path
   logic nor_rd_valid = 1'b0, nor_rd_ready, nor_rd_done, nor_rd_page_hit;
   logic [1:0] nor_rd_cs = 2'h0;
   logic [21:0] nor_rd_addr = 22'h0;
   logic sd_cmd_valid = 1'b0, sd_cmd_ready, sd_cmd_issue, sd_cke;
   logic sd_init_start, bad, en, len;
   logic [2:0] sd_cmd_kind = 3'h0, sd_issue_kind;
   logic [1:0] sd_cmd_bank = 2'h0, r;
   // Bench working values
   int gap, xs_gap, c, n, b;
   logic [31:0] v, pm, t;
   logic [21:0] a;
   logic [5:0] d;
   logic [4:0] x;

   mem_ctl_timing #(.ADDR_W(22), .FULL_READ_CYCLES(12)) DUT (.*);
   sdram_model far_i (.aclk(aclk), .sd_cmd_issue(sd_cmd_issue),
      .sd_issue_kind(sd_issue_kind), .sd_cke(sd_cke), .gap(gap),
      .xs_gap(xs_gap), .bad(bad));

   always #2 aclk = ~aclk;
   // Count initialization pulses
   always @(posedge aclk) if (sd_init_start === 1'b1) init_seen++;

   // Compare and count
   task chk(input logic [31:0] s, input logic [31:0] e, input string m);
      total_checks++;
      if (s !== e)
      begin
         errors++;
         $display("[ERR] %0t %s seen %h exp %h", $time, m, s, e);
      end
   endtask : chk

   // Register write, both halves offered together
   task wr(input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] s);
      logic ah, wh;
      ah = 1'b0;
      wh = 1'b0;
      s_axi_awaddr <= ad;
      s_axi_wdata <= dt;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(ah && wh))
      begin
         @(posedge aclk);
         if (!ah && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (!wh && s_axi_wready) s_axi_wvalid <= 1'b0;
         ah = ah | s_axi_awready;
         wh = wh | s_axi_wready;
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
   endtask : wr

   // Register read
   task rd(input logic [7:0] ad);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      r = s_axi_rresp;
   endtask : rd

   // Page read; n counts edges from take to done, 99 if none
   task nor_read(input logic [1:0] cs, input logic [21:0] ad);
      nor_rd_cs <= cs;
      nor_rd_addr <= ad;
      nor_rd_valid <= 1'b1;
      do @(posedge aclk); while (nor_rd_ready !== 1'b1);
      nor_rd_valid <= 1'b0;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (nor_rd_done !== 1'b1 && n < 99);
   endtask : nor_read

   // Offer an SDRAM command; valid stays up for back-to-back use
   task sd_send(input logic [2:0] k);
      sd_cmd_kind <= k;
      sd_cmd_bank <= 2'($random(seed));
      sd_cmd_valid <= 1'b1;
      do @(posedge aclk); while (sd_cmd_ready !== 1'b1);
   endtask : sd_send

   // Wait for the clock enable level
   task wait_cke(input logic lvl);
      int w;
      w = 0;
      while (sd_cke !== lvl && w < 300)
      begin
         @(posedge aclk);
         w++;
      end
      chk(sd_cke, lvl, "cke level");
   endtask : wait_cke

   // Shortest legal spacing after a command kind
   function automatic int min_gap(input logic [2:0] k, input logic [31:0] tm);
      case (k)
         3'h0: return int'(tm[22:20]) + 1;
         3'h2: return int'(tm[18:16]) + 1;
         3'h3: return int'(tm[26:24]) + 1;
         3'h4: return int'(tm[31:27]) + 1;
         default: return 1;
      endcase
   endfunction : min_gap

   // Verdict and end of run
   task report_and_stop;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop

   // Watchdog
   initial
   begin
      #200000;
      errors++;
      report_and_stop;
   end

   // Main sequence
   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(mem_ctl_pkg::OFS_PAGE_MODE);
      chk(v, {4{8'hFC}}, "page reset");
      rd(mem_ctl_pkg::OFS_SR_EXIT_TIMING);
      chk(v, mem_ctl_pkg::RST_SR_EXIT_TIMING, "exit reset");
      rd(mem_ctl_pkg::OFS_STATUS);
      chk(v, 32'h0000_000C, "status idle");
      rd(8'h04);
      chk(r, mem_ctl_pkg::RESP_SLVERR, "unmapped read");
      wr(8'h10, 32'hFFFF_FFFF, 4'hF);
      chk(r, mem_ctl_pkg::RESP_SLVERR, "unmapped write");
      $display("test reset done");
      // Every select with every enable and length setting
      for (int i = 0; i < 12; i++)
      begin
         c = i % 3;
         en = 1'((i / 3) % 2);
         len = 1'(i / 6);
         d = 6'(({$random(seed)} % 63) + 1);
         pm = $random(seed) | 32'h0404_0404;
         pm[c*8 +: 8] = {d, len, en};
         wr(mem_ctl_pkg::OFS_PAGE_MODE, pm, 4'hF);
         rd(mem_ctl_pkg::OFS_PAGE_MODE);
         chk(v, pm, "page rw");
         a = 22'($random(seed)) & 22'h3F_FFF8;
         nor_read(2'(c), a);
         nor_read(2'((c + 1) % 3), a ^ 22'h10);
         nor_read(2'(c), a + 22'h1);
         chk(nor_rd_page_hit, en, "same page");
         if (en) chk(n, d + 2, "hit latency");
         nor_read(2'(c), a + 22'h4);
         chk(nor_rd_page_hit, en & len, "page length");
      end
      // Absent select enabled, select a disabled
      wr(mem_ctl_pkg::OFS_PAGE_MODE, 32'h0704_0404, 4'hF);
      nor_read(2'h0, a);
      nor_read(2'h0, a + 22'h1);
      chk(nor_rd_page_hit, 1'b0, "absent fields");
      nor_read(2'h3, a);
      chk(n, 99, "absent select");
      $display("test page done");
      t = $random(seed);
      wr(mem_ctl_pkg::OFS_SDRAM_TIMING, t, 4'hF);
      rd(mem_ctl_pkg::OFS_SDRAM_TIMING);
      chk(v, t & mem_ctl_pkg::MSK_SDRAM_TIMING, "timing rw");
      x = 5'($random(seed));
      wr(mem_ctl_pkg::OFS_SR_EXIT_TIMING, {27'h0, x}, 4'hF);
      for (int k = 0; k < 5; k++)
      begin
         sd_send(3'(k));
         sd_send(3'h1);
         sd_cmd_valid <= 1'b0;
         repeat (2) @(posedge aclk);
         chk(gap >= min_gap(3'(k), t), 1'b1, "spacing");
      end
      $display("test sdram done");
      b = init_seen;
      wr(mem_ctl_pkg::OFS_SDRAM_CFG, 32'h8000_0000, 4'h8);
      wait_cke(1'b0);
      chk(sd_issue_kind, 3'h5, "entry kind");
      wr(mem_ctl_pkg::OFS_SDRAM_CFG, 32'h0, 4'h8);
      wait_cke(1'b1);
      sd_send(3'h0);
      sd_cmd_valid <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(xs_gap >= x + 1, 1'b1, "exit wait");
      chk(init_seen, b, "no init");
      chk(bad, 1'b0, "command in refresh");
      wr(mem_ctl_pkg::OFS_SDRAM_CFG, 32'h0000_4720, 4'hF);
      repeat (4) @(posedge aclk);
      chk(init_seen, b + 1, "init pulse");
      $display("test selfref done");
      report_and_stop;
   end
endmodule : tb_top
